//--- scp_top.v
// system clock prescaler: apb registers, change window, divider and clock output pin
`timescale 1ns/100ps
module scp_top #(
    parameter ADDR_W = 12,
    parameter CNT_W = 8
) (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // configuration fuses, static levels
    input wire clock_output_fuse,
    input wire divide_by_eight_fuse,
    // normal port function of the shared pin
    input wire gpio_o,
    input wire gpio_oe,
    // shared pin driver
    output reg clock_out_pin_o,
    output reg clock_out_pin_oe,
    // clock enables of the divided domains
    output wire cpu_clk_en,
    output wire io_clk_en,
    output wire adc_clk_en,
    output wire flash_clk_en
);

`include "scp_defines.vh"

// bus decode
wire access;
wire wr_fire;
wire rd_take;
wire hit_ctrl;
wire hit_stat;
wire hit_any;
wire [7:0] wbyte;
wire ctrl_wr;
wire stat_wr;

// control state
reg init_q;
reg fuse_out_q;
reg fuse_div8_q;
reg ce_q;
reg ce_d;
reg [2:0] ce_cnt_q;
reg [2:0] ce_cnt_d;
reg [3:0] sel_q;
reg [3:0] sel_d;
reg rej_q;
reg rej_d;
reg sys_tick_q;

// divider outputs
wire div_tick;
wire div_level;
wire [3:0] div_active;

// write qualifiers
wire ce_set_req;
wire sel_wr;
wire sel_bad;
wire rej_clr;

// read mux
reg [31:0] rdata_d;
wire [7:0] ctrl_view;
wire [8:0] stat_view;

assign access = psel & penable;
assign wr_fire = access & pready & pwrite;
assign rd_take = access & ~pready;
assign hit_ctrl = (paddr == `SCP_CTRL_OFFSET);
assign hit_stat = (paddr == `SCP_STAT_OFFSET);
assign hit_any = hit_ctrl | hit_stat;
assign wbyte = pwdata[7:0];
assign ctrl_wr = wr_fire & hit_ctrl & pstrb[0];
assign stat_wr = wr_fire & hit_stat & pstrb[1];

// one wait state per transfer so read data can leave a flop
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else begin
        pready <= rd_take;
        pslverr <= rd_take & ~hit_any;
        if (rd_take & ~pwrite) begin
            prdata <= rdata_d;
        end
    end
end

// the set write must carry zeros in every other bit of the low byte
assign ce_set_req = ctrl_wr & (wbyte == `SCP_CE_SET_VALUE);
// a select write is one with the enable bit clear, taken only while the window is open
assign sel_wr = ctrl_wr & ~wbyte[`SCP_CE_BIT] & ce_q;
// a select write outside the window is dropped and remembered
assign sel_bad = ctrl_wr & ~wbyte[`SCP_CE_BIT] & ~ce_q;
assign rej_clr = stat_wr & pwdata[`SCP_STAT_REJ_BIT];

// change window
always @* begin
    ce_d = ce_q;
    ce_cnt_d = ce_cnt_q;
    if (sel_wr) begin
        ce_d = 1'b0;
        ce_cnt_d = 3'h0;
    end else if (ce_q) begin
        // a repeated set write falls through here untouched
        ce_cnt_d = ce_cnt_q - `SCP_CE_LAST;
        if (ce_cnt_q == `SCP_CE_LAST) begin
            ce_d = 1'b0;
        end
    end else if (ce_set_req) begin
        ce_d = 1'b1;
        ce_cnt_d = `SCP_CE_CYCLES;
    end
end

// select field; any value is taken inside the window whatever the fuse says
always @* begin
    sel_d = sel_q;
    if (!init_q) begin
        // the fuse flop is loaded on this same edge, so the live fuse level is used here
        sel_d = divide_by_eight_fuse ? `SCP_SEL_DIV8 : `SCP_SEL_RESET;
    end else if (sel_wr) begin
        sel_d = wbyte[`SCP_SEL_MSB:`SCP_SEL_LSB];
    end
end

// rejected-write flag: a new rejection in the clearing cycle wins
always @* begin
    rej_d = rej_q;
    if (rej_clr) begin
        rej_d = 1'b0;
    end
    if (sel_bad) begin
        rej_d = 1'b1;
    end
end

// fuses are caught on the first edge after reset release, never under reset
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        init_q <= 1'b0;
        fuse_out_q <= 1'b0;
        fuse_div8_q <= 1'b0;
    end else begin
        init_q <= 1'b1;
        if (!init_q) begin
            fuse_out_q <= clock_output_fuse;
            fuse_div8_q <= divide_by_eight_fuse;
        end
    end
end

// register state
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ce_q <= 1'b0;
        ce_cnt_q <= 3'h0;
        sel_q <= `SCP_SEL_RESET;
        rej_q <= 1'b0;
    end else begin
        ce_q <= ce_d;
        ce_cnt_q <= ce_cnt_d;
        sel_q <= sel_d;
        rej_q <= rej_d;
    end
end

// reserved bits always read back as zero
assign ctrl_view = {ce_q, `SCP_RSVD_ZERO, sel_q};

assign stat_view = {
    rej_q,
    fuse_div8_q,
    fuse_out_q,
    (div_active != sel_q),
    ce_q,
    div_active
};

always @* begin
    rdata_d = 32'h00000000;
    if (hit_ctrl) begin
        rdata_d[7:0] = ctrl_view;
    end else if (hit_stat) begin
        rdata_d[`SCP_STAT_REJ_BIT:0] = stat_view;
    end
end

// the divider runs from the source clock whatever source feeds pclk
scp_divider #(
    .CNT_W(CNT_W)
) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .sel_i(sel_q),
    .tick_q(div_tick),
    .level_q(div_level),
    .active_q(div_active)
);

// one registered tick feeds every domain, so they never drift apart
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sys_tick_q <= 1'b0;
    end else begin
        sys_tick_q <= div_tick;
    end
end

assign cpu_clk_en = sys_tick_q;
assign io_clk_en = sys_tick_q;
assign adc_clk_en = sys_tick_q;
assign flash_clk_en = sys_tick_q;

// shared pin: the fuse takes it from the port logic and drives the divided clock
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        clock_out_pin_o <= 1'b0;
        clock_out_pin_oe <= 1'b0;
    end else if (!init_q) begin
        // fuses are not known yet; keep the pin quiet one more cycle
        clock_out_pin_o <= 1'b0;
        clock_out_pin_oe <= 1'b0;
    end else if (fuse_out_q) begin
        clock_out_pin_o <= div_level;
        clock_out_pin_oe <= 1'b1;
    end else begin
        clock_out_pin_o <= gpio_o;
        clock_out_pin_oe <= gpio_oe;
    end
end

endmodule // scp_top

//--- scp_defines.vh
// constants shared by the system clock prescaler design files
// What this block does
// - clock fuse routes system clock onto pin
// - no clock on pin during reset
// - clock output works for every source
// - pin carries the divided system clock, at half rate for ratio one
// - one ratio drives cpu, io, adc, flash
// - enable sets only on exact 0x80 write
// - enable clears after four cycles or select write
// - rewriting enable neither restarts nor clears window
// - bits six to four read zero
// - select field sets ratio, changeable at run time
// - select accepted only inside the enable window
// - reset select 0000, or 0011 with fuse
// - any select value writable after reset
`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH

// register byte offsets
`define SCP_CTRL_OFFSET 12'h000
`define SCP_STAT_OFFSET 12'h004

// control register layout
`define SCP_CE_BIT 7
`define SCP_SEL_MSB 3
`define SCP_SEL_LSB 0
`define SCP_CE_SET_VALUE 8'h80
`define SCP_RSVD_ZERO 3'h0

// status register layout
`define SCP_STAT_ACT_MSB 3
`define SCP_STAT_ACT_LSB 0
`define SCP_STAT_WIN_BIT 4
`define SCP_STAT_PEND_BIT 5
`define SCP_STAT_OUTF_BIT 6
`define SCP_STAT_DIV8F_BIT 7
`define SCP_STAT_REJ_BIT 8

// reset values of the select field
`define SCP_SEL_RESET 4'h0
`define SCP_SEL_DIV8 4'h3

// change window length in clock cycles
`define SCP_CE_CYCLES 3'h4
`define SCP_CE_LAST 3'h1

// largest legal select value; 9 to 15 act as this one
`define SCP_SEL_MAX 4'h8

`endif

//--- scp_divider.v
// power-of-two clock divider producing a tick and a clock level
`timescale 1ns/100ps
module scp_divider #(
    parameter CNT_W = 8
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // ratio request
    input wire [3:0] sel_i,
    // divided clock
    output reg tick_q,
    output reg level_q,
    output reg [3:0] active_q
);

`include "scp_defines.vh"

reg [CNT_W-1:0] cnt_q;
reg [CNT_W-1:0] cnt_d;
reg [3:0] active_d;
reg [3:0] eff_now;
reg [3:0] eff_next;
reg [CNT_W:0] term_now;
reg [CNT_W:0] term_next;
reg wrap;

// new ratios are taken only at a period boundary, so no runt pulse reaches a domain
always @* begin
    eff_now = (active_q > `SCP_SEL_MAX) ? `SCP_SEL_MAX : active_q;
    term_now = ({{CNT_W{1'b0}}, 1'b1} << eff_now) - {{CNT_W{1'b0}}, 1'b1};
    wrap = (cnt_q == term_now[CNT_W-1:0]);
    active_d = wrap ? sel_i : active_q;
    cnt_d = wrap ? {CNT_W{1'b0}} : cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    eff_next = (active_d > `SCP_SEL_MAX) ? `SCP_SEL_MAX : active_d;
    term_next = ({{CNT_W{1'b0}}, 1'b1} << eff_next) - {{CNT_W{1'b0}}, 1'b1};
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cnt_q <= {CNT_W{1'b0}};
        active_q <= `SCP_SEL_RESET;
        tick_q <= 1'b0;
        level_q <= 1'b0;
    end else begin
        cnt_q <= cnt_d;
        active_q <= active_d;
        tick_q <= wrap;
        // ratio one cannot be shown by a flop; it toggles at half rate instead
        if (eff_next == `SCP_SEL_RESET) begin
            level_q <= ~level_q;
        end else begin
            level_q <= (cnt_d <= term_next[CNT_W:1]);
        end
    end
end

endmodule // scp_divider

//--- scp_assertions.sv
// port checker for the system clock prescaler
`timescale 1ns/100ps
module scp_assertions #(
    parameter ADDR_W = 12
) (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // fuse and pin
    input wire clock_output_fuse,
    input wire gpio_o,
    input wire clock_out_pin_o,
    input wire clock_out_pin_oe,
    // domain enables
    input wire cpu_clk_en,
    input wire io_clk_en,
    input wire adc_clk_en,
    input wire flash_clk_en
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_done = pready && !pwrite;

    en_same_a: assert property (cpu_clk_en == io_clk_en && io_clk_en == adc_clk_en
        && adc_clk_en == flash_clk_en) else $error("domain enables differ");
    pin_drive_a: assert property (clock_output_fuse |-> ##2 clock_out_pin_oe)
        else $error("pin not driven");
    pin_gpio_a: assert property (!clock_output_fuse && $past(presetn)
        |=> clock_out_pin_o == $past(gpio_o)) else $error("pin lost port value");
    // only the first edge after release is visible while reset gates the rest
    pin_rst_a: assert property ($rose(presetn) |-> !clock_out_pin_o && !clock_out_pin_oe)
        else $error("pin active in reset");
    rsvd_zero_a: assert property (rd_done && paddr == 12'h000
        |-> prdata[31:8] == 24'h0 && prdata[6:4] == 3'h0) else $error("reserved bits set");
    ready_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("ready timing");
    err_qual_a: assert property (pslverr |-> pready) else $error("stray error");
    unmap_err_a: assert property (pready && paddr != 12'h000 && paddr != 12'h004 |-> pslverr)
        else $error("unmapped without error");

    cover property (rd_done && paddr == 12'h000 && prdata[3:0] == 4'h9);
    cover property ($rose(clock_out_pin_o));
    cover property (pslverr);
endmodule // scp_assertions

//--- scp_tb.sv
// self-checking bench for the system clock prescaler
`timescale 1ns/100ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic fo = 1'b0;
    logic fd = 1'b0;
    logic [1:0] gp = 2'h0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, err, pin_o, pin_oe, cpu_en, io_en, adc_en, fl_en;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;

    always #4 pclk = ~pclk;
    // port function keeps moving so a stuck pin register shows
    always @(posedge pclk) gp <= gp + 2'h1;

    scp_top u_scp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clock_output_fuse(fo),
        .divide_by_eight_fuse(fd), .gpio_o(gp[0]), .gpio_oe(gp[1]),
        .clock_out_pin_o(pin_o), .clock_out_pin_oe(pin_oe), .cpu_clk_en(cpu_en),
        .io_clk_en(io_en), .adc_clk_en(adc_en), .flash_clk_en(fl_en));

    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    endtask

    task conclude;
        $display("mismatches %0d, compares %0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // leaves the request up; the next call or idle releases it
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdata = prdata;
        err = pslverr;
    endtask

    task idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask

    task do_reset(input logic o, input logic d);
        presetn <= 1'b0;
        fo <= o;
        fd <= d;
        repeat (20) @(posedge pclk);
        chk({30'h0, pin_o, pin_oe}, 32'h0);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    task t_rst(input logic [31:0] e);
        acc(1'b0, 12'h000, 32'h0);
        chk(rdata, e);
        idle(1);
    endtask

    task t_seq(input logic [31:0] a, input int gap, input logic rew, input logic [31:0] b,
               input logic [3:0] e);
        acc(1'b1, 12'h000, a);
        if (rew)
            acc(1'b1, 12'h000, 32'h80);
        if (gap > 0)
            idle(gap);
        acc(1'b1, 12'h000, b);
        idle(1);
        acc(1'b0, 12'h000, 32'h0);
        chk(rdata, {28'h0, e});
        idle(1);
    endtask

    // rejected select writes leave a sticky status flag that a one clears
    task t_stat;
        acc(1'b0, 12'h004, 32'h0);
        chk({29'h0, rdata[8:6]}, 32'h7);
        acc(1'b1, 12'h004, 32'h100);
        acc(1'b0, 12'h004, 32'h0);
        chk({29'h0, rdata[8:6]}, 32'h3);
        idle(1);
    endtask

    task t_div;
        int n;
        int h;
        for (int i = 0; i < 10; i++) begin
            acc(1'b1, 12'h000, 32'h80);
            acc(1'b1, 12'h000, i);
            idle(1);
            repeat (3) begin
                @(posedge pclk);
                while (cpu_en !== 1'b1)
                    @(posedge pclk);
            end
            n = 0;
            h = 0;
            do begin
                @(posedge pclk);
                n++;
                h += pin_o;
            end while (cpu_en !== 1'b1);
            chk(n, i > 8 ? 256 : 1 << i);
            if (i > 0)
                chk(h, (i > 8 ? 256 : 1 << i) / 2);
        end
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            conclude;
        end
    end

    initial begin
        do_reset(1'b1, 1'b1);
        t_rst(32'h3);
        t_seq(32'h80, 1, 1'b0, 32'h5, 4'h5);
        t_seq(32'h80, 2, 1'b0, 32'h6, 4'h5);
        t_seq(32'h81, 0, 1'b0, 32'h6, 4'h5);
        t_seq(32'hF0, 0, 1'b0, 32'h6, 4'h5);
        t_stat();
        t_seq(32'h80, 0, 1'b1, 32'h6, 4'h5);
        t_seq(32'h80, 0, 1'b0, 32'h7C, 4'hC);
        t_div();
        acc(1'b0, 12'h000, 32'h0);
        chk(rdata, 32'h9);
        acc(1'b0, 12'h010, 32'h0);
        chk({31'h0, err}, 32'h1);
        idle(1);
        do_reset(1'b0, 1'b0);
        t_rst(32'h0);
        t_seq(32'h80, 0, 1'b0, 32'hF, 4'hF);
        conclude;
    end
endmodule // tb

bind scp_top scp_assertions #(.ADDR_W(ADDR_W)) u_scp_assertions (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_output_fuse(clock_output_fuse), .gpio_o(gpio_o),
    .clock_out_pin_o(clock_out_pin_o), .clock_out_pin_oe(clock_out_pin_oe),
    .cpu_clk_en(cpu_clk_en), .io_clk_en(io_clk_en), .adc_clk_en(adc_clk_en),
    .flash_clk_en(flash_clk_en));
